// File: timer_pkg.sv
// Shared constants, register map and carrier types of the timer unit.
// Assumes one clock domain and a 32-bit AXI4-Lite register port.
package timer_pkg;

   // ------------------------------------------------------------
   // Timer indices and group timing
   // ------------------------------------------------------------
   localparam int NUM_TIMERS = 5;
   localparam int AUX_LOW = 0;
   localparam int CORE = 1;
   localparam int AUX_HIGH = 2;
   localparam int FAST_AUX = 3;
   localparam int FAST_CORE = 4;
   localparam int TIMER_W = 16;
   localparam int SLOW_BASE_LOG = 2;
   localparam int FAST_BASE_LOG = 1;
   localparam int PRESC_STEPS = 8;

   // ------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CFG_ADDR = 8'h00;
   localparam logic [7:0] VAL_ADDR = 8'h20;
   localparam logic [7:0] CAPREG_ADDR = 8'h40;
   localparam logic [7:0] FAST_CTRL_ADDR = 8'h44;
   localparam logic [7:0] FLAGS_ADDR = 8'h48;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] VAL_RST = 16'h0000;
   localparam logic [5:0] FAST_CTRL_RST = 6'h00;
   localparam int FLAGS_W = 9;
   localparam int FLG_CAP_LOW = 5;
   localparam int FLG_CAP_HIGH = 6;
   localparam int FLG_CAPREG = 7;
   localparam int FLG_INDEX = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Modes and configuration layouts
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_GATED = 2'b01,
      MODE_COUNTER = 2'b10,
      MODE_INCR = 2'b11
   } mode_t;

   typedef enum logic [1:0] {
      ROLE_TIMER = 2'b00,
      ROLE_RELOAD = 2'b01,
      ROLE_CAPTURE = 2'b10,
      ROLE_SPARE = 2'b11
   } role_t;

   typedef struct packed {
      logic rsvd;
      logic out_en;
      role_t role;
      logic src_otl;
      logic [1:0] edge_sel;
      logic gate_lvl;
      logic ext_dir;
      logic count_down;
      logic [2:0] presc;
      logic run;
      mode_t mode;
   } cfg_t;

   typedef struct packed {
      logic clr_aux;
      logic reload_en;
      logic dir_pin_trig;
      logic cnt_pin_trig;
      logic [1:0] cap_edge;
   } fast_ctrl_t;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;

   // Edge match: sel[0] rising, sel[1] falling
   function automatic logic edge_hit(input logic prev, input logic now, input logic [1:0] sel);
      edge_hit = (sel[0] & ~prev & now) | (sel[1] & prev & ~now);
   endfunction

endpackage

// File: tick_divider.sv
// Free-running divider giving one-cycle prescaler enables.
// Assumes a single clock; tick[i] fires every 2**(BASE_LOG+i) cycles.
module tick_divider #(
   parameter int BASE_LOG = 2,
   parameter int STEPS = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic [STEPS-1:0] tick
);
   localparam int CW = BASE_LOG + STEPS - 1;

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [CW-1:0] mask;

   always_comb begin
      mask = '0;
      cnt_nxt = cnt_r + 1'b1;
      for (int i = 0; i < STEPS; i++) begin
         mask = CW'((64'h1 << (BASE_LOG + i)) - 64'h1);
         tick[i] = &(cnt_r | ~mask);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// File: updown_counter.sv
// One up/down timer cell with synchronous load.
// Assumes load has priority over a count step in the same cycle.
module updown_counter #(
   parameter int WIDTH = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic step,
   input wire logic up,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_val,
   output logic [WIDTH-1:0] value,
   output logic wrap
);
   logic [WIDTH-1:0] value_r;
   logic [WIDTH-1:0] value_nxt;

   always_comb begin
      wrap = step & ~load & (up ? (&value_r) : ~(|value_r));
      value_nxt = value_r;
      if (load) begin
         value_nxt = load_val;
      end else if (step) begin
         value_nxt = up ? value_r + 1'b1 : value_r - 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value_r <= '0;
      end else begin
         value_r <= value_nxt;
      end
   end

   assign value = value_r;
endmodule

// File: dual_module_timer_unit.sv
// Five 16-bit up/down timers in a slow and a fast group, set up over AXI4-Lite.
// Assumes pins are synchronous to aclk and the bus master keeps AXI4-Lite handshakes.
//
// Notes on behaviour
// - Five 16-bit timers: three slow, two fast plus capture/reload register.
// - Timers chain only inside their own group.
// - Slow timers pick timer, gated, counter or incremental mode.
// - Timer mode counts system clock through programmable prescaler.
// - Counter mode steps on edges of the timer input pin.
// - Gated mode counts prescaled ticks only at active gate level.
// - Slow timers step at most once every four clocks.
// - Direction from software bit, optionally flipped by direction pin.
// - Incremental mode decodes quadrature pins into steps and direction.
// - Core toggle latch flips on each wrap, may drive pin.
// - Core toggle latch may clock both auxiliary slow timers.
// - Auxiliary timer in capture or reload role stops counting.
// - Capture role latches core timer on selected input pin edge.
// - Reload role loads core from auxiliary on pin or latch edge.
// - Two reload roles on opposite latch edges give free PWM.
// - Fast timers step at most once every two clocks.
// - Fast timers run from prescaler or from pin events.
// - Fast toggle latch flips on wrap, clocks fast aux, drives pin.
// - Fast core wraps export a clock and may reload from register.
// - Register captures fast aux on capture pin edge, optional clear.
// - Capture may also trigger on core count or direction pin changes.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
module dual_module_timer_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire timer_pkg::axi_req_t s_axi_req,
   output timer_pkg::axi_rsp_t s_axi_rsp,
   input wire logic [4:0] timer_input_pin,
   input wire logic [4:0] direction_input_pin,
   input wire logic capture_input_pin,
   input wire logic index_pulse_input,
   output logic core_toggle_out_pin,
   output logic fast_toggle_out_pin,
   output logic compare_clock_out
);
   localparam int N = timer_pkg::NUM_TIMERS;
   localparam int W = timer_pkg::TIMER_W;

   // ------------------------------------------------------------
   // Prescalers and timer cells
   // ------------------------------------------------------------
   logic [timer_pkg::PRESC_STEPS-1:0] slow_tick;
   logic [timer_pkg::PRESC_STEPS-1:0] fast_tick;
   logic [N-1:0] step;
   logic [N-1:0] up;
   logic [N-1:0] load;
   logic [N-1:0] wrap;
   logic [W-1:0] load_val [N];
   logic [W-1:0] tval [N];

   tick_divider #(.BASE_LOG(timer_pkg::SLOW_BASE_LOG), .STEPS(timer_pkg::PRESC_STEPS)) u_slow_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(slow_tick)
   );

   tick_divider #(.BASE_LOG(timer_pkg::FAST_BASE_LOG), .STEPS(timer_pkg::PRESC_STEPS)) u_fast_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(fast_tick)
   );

   for (genvar g = 0; g < N; g++) begin : gen_tmr
      updown_counter #(.WIDTH(W)) u_cnt (
         .aclk(aclk),
         .aresetn(aresetn),
         .step(step[g]),
         .up(up[g]),
         .load(load[g]),
         .load_val(load_val[g]),
         .value(tval[g]),
         .wrap(wrap[g])
      );
   end

   // ------------------------------------------------------------
   // Register and pin state
   // ------------------------------------------------------------
   timer_pkg::cfg_t cfg_r [N];
   timer_pkg::cfg_t cfg_nxt [N];
   timer_pkg::fast_ctrl_t fctl_r;
   timer_pkg::fast_ctrl_t fctl_nxt;
   logic [W-1:0] fast_capture_reload_reg_r;
   logic [W-1:0] fast_capture_reload_reg_nxt;
   logic [timer_pkg::FLAGS_W-1:0] flags_r;
   logic [timer_pkg::FLAGS_W-1:0] flags_nxt;
   logic [N-1:0] pin_r;
   logic [N-1:0] pin_nxt;
   logic [N-1:0] dpin_r;
   logic [N-1:0] dpin_nxt;
   logic [2:0] fpin_r;
   logic [2:0] fpin_nxt;
   logic idx_r;
   logic idx_nxt;
   logic core_otl_r;
   logic core_otl_nxt;
   logic fast_otl_r;
   logic fast_otl_nxt;
   logic core_out_r;
   logic core_out_nxt;
   logic fast_out_r;
   logic fast_out_nxt;
   logic cmp_clk_r;
   logic cmp_clk_nxt;

   // Bus state
   logic awready_r;
   logic awready_nxt;
   logic wready_r;
   logic wready_nxt;
   logic bvalid_r;
   logic bvalid_nxt;
   logic [1:0] bresp_r;
   logic [1:0] bresp_nxt;
   logic arready_r;
   logic arready_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_r;
   logic [1:0] rresp_nxt;
   logic [7:0] awaddr_r;
   logic [7:0] awaddr_nxt;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic [3:0] wstrb_r;
   logic [3:0] wstrb_nxt;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   logic wr_go;
   logic [5:0] wr_idx;
   logic [N-1:0] wr_cfg;
   logic [N-1:0] wr_val;
   logic wr_capreg;
   logic wr_fctl;
   logic wr_flags;
   logic wr_hit;

   always_comb begin
      wr_go = ~awready_r & ~wready_r & ~bvalid_r;
      wr_idx = awaddr_r[7:2];
      for (int i = 0; i < N; i++) begin
         wr_cfg[i] = wr_go & (wr_idx == timer_pkg::CFG_ADDR[7:2] + 6'(i));
         wr_val[i] = wr_go & (wr_idx == timer_pkg::VAL_ADDR[7:2] + 6'(i));
      end
      wr_capreg = wr_go & (wr_idx == timer_pkg::CAPREG_ADDR[7:2]);
      wr_fctl = wr_go & (wr_idx == timer_pkg::FAST_CTRL_ADDR[7:2]);
      wr_flags = wr_go & (wr_idx == timer_pkg::FLAGS_ADDR[7:2]);
      wr_hit = (|wr_cfg) | (|wr_val) | wr_capreg | wr_fctl | wr_flags;
   end

   // ------------------------------------------------------------
   // Timer event logic
   // ------------------------------------------------------------
   logic [N-1:0] base;
   logic [N-1:0] tin_ev;
   logic [N-1:0] ev;
   logic [N-1:0] quad_step;
   logic [N-1:0] quad_up;
   logic [N-1:0] a_ch;
   logic [N-1:0] b_ch;
   logic [N-1:0] presc_tick;
   logic [N-1:0] cap_ev;
   logic [N-1:0] rel_ev;
   logic capreg_trig;

   always_comb begin
      capreg_trig = 1'b0;
      for (int i = 0; i < N; i++) begin
         // Each group takes only its own base and latch
         base[i] = (i < timer_pkg::FAST_AUX) ? slow_tick[0] : fast_tick[0];
         presc_tick[i] = (i < timer_pkg::FAST_AUX) ? slow_tick[cfg_r[i].presc] : fast_tick[cfg_r[i].presc];
         tin_ev[i] = base[i] & timer_pkg::edge_hit(pin_r[i], timer_input_pin[i], cfg_r[i].edge_sel);
         ev[i] = tin_ev[i];
         // Core latch edges as aux count source
         if (cfg_r[i].src_otl && (i == timer_pkg::AUX_LOW || i == timer_pkg::AUX_HIGH)) begin
            ev[i] = wrap[timer_pkg::CORE] & timer_pkg::edge_hit(core_otl_r, ~core_otl_r, cfg_r[i].edge_sel);
         end
         // Fast latch edges clock the fast aux
         if (cfg_r[i].src_otl && i == timer_pkg::FAST_AUX) begin
            ev[i] = wrap[timer_pkg::FAST_CORE] & timer_pkg::edge_hit(fast_otl_r, ~fast_otl_r, cfg_r[i].edge_sel);
         end
         // Quadrature decode, a double change is dropped
         a_ch[i] = base[i] & (pin_r[i] ^ timer_input_pin[i]);
         b_ch[i] = base[i] & (dpin_r[i] ^ direction_input_pin[i]);
         quad_step[i] = a_ch[i] ^ b_ch[i];
         quad_up[i] = a_ch[i] ? (timer_input_pin[i] ^ dpin_r[i]) : ~(pin_r[i] ^ direction_input_pin[i]);
         // Software direction, optionally flipped by pin
         up[i] = ~(cfg_r[i].count_down ^ (cfg_r[i].ext_dir & dpin_r[i]));
         step[i] = 1'b0;
         case (cfg_r[i].mode)
            timer_pkg::MODE_TIMER: begin
               step[i] = presc_tick[i];
            end
            timer_pkg::MODE_GATED: begin
               step[i] = presc_tick[i] & (pin_r[i] == cfg_r[i].gate_lvl);
            end
            timer_pkg::MODE_COUNTER: begin
               step[i] = ev[i];
            end
            timer_pkg::MODE_INCR: begin
               if (i < timer_pkg::FAST_AUX) begin
                  step[i] = quad_step[i];
                  up[i] = quad_up[i];
               end
            end
            default: begin
               step[i] = 1'b0;
            end
         endcase
         cap_ev[i] = 1'b0;
         rel_ev[i] = 1'b0;
         if (i == timer_pkg::AUX_LOW || i == timer_pkg::AUX_HIGH) begin
            cap_ev[i] = (cfg_r[i].role == timer_pkg::ROLE_CAPTURE) & tin_ev[i];
            // Reload on pin or latch edge
            rel_ev[i] = (cfg_r[i].role == timer_pkg::ROLE_RELOAD) & ev[i];
            if (cfg_r[i].role == timer_pkg::ROLE_CAPTURE || cfg_r[i].role == timer_pkg::ROLE_RELOAD) begin
               step[i] = 1'b0;
            end
         end
         step[i] = step[i] & cfg_r[i].run;
         load[i] = cap_ev[i];
         load_val[i] = tval[timer_pkg::CORE];
      end
      // Reload of the core, low aux first
      load[timer_pkg::CORE] = rel_ev[timer_pkg::AUX_LOW] | rel_ev[timer_pkg::AUX_HIGH];
      load_val[timer_pkg::CORE] = rel_ev[timer_pkg::AUX_LOW] ? tval[timer_pkg::AUX_LOW] : tval[timer_pkg::AUX_HIGH];
      // Fast core reload from capture register
      load[timer_pkg::FAST_CORE] = wrap[timer_pkg::FAST_CORE] & fctl_r.reload_en;
      load_val[timer_pkg::FAST_CORE] = fast_capture_reload_reg_r;
      capreg_trig = fast_tick[0] & (timer_pkg::edge_hit(fpin_r[0], capture_input_pin, fctl_r.cap_edge)
         | (fctl_r.cnt_pin_trig & (fpin_r[1] ^ timer_input_pin[timer_pkg::CORE]))
         | (fctl_r.dir_pin_trig & (fpin_r[2] ^ direction_input_pin[timer_pkg::CORE])));
      load[timer_pkg::FAST_AUX] = capreg_trig & fctl_r.clr_aux;
      load_val[timer_pkg::FAST_AUX] = '0;
      // Software writes win over hardware loads
      for (int i = 0; i < N; i++) begin
         if (wr_val[i]) begin
            load[i] = 1'b1;
            load_val[i] = wmerge(tval[i], wdata_r, wstrb_r);
         end
      end
   end

   // ------------------------------------------------------------
   // Configuration, latches, flags and pins
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < N; i++) begin
         cfg_nxt[i] = wr_cfg[i] ? timer_pkg::cfg_t'(wmerge(16'(cfg_r[i]), wdata_r, wstrb_r)) : cfg_r[i];
         pin_nxt[i] = base[i] ? timer_input_pin[i] : pin_r[i];
         dpin_nxt[i] = base[i] ? direction_input_pin[i] : dpin_r[i];
      end
      fctl_nxt = fctl_r;
      if (wr_fctl && wstrb_r[0]) begin
         fctl_nxt = timer_pkg::fast_ctrl_t'(wdata_r[5:0]);
      end
      fpin_nxt = fast_tick[0]
         ? {direction_input_pin[timer_pkg::CORE], timer_input_pin[timer_pkg::CORE], capture_input_pin} : fpin_r;
      idx_nxt = index_pulse_input;
      fast_capture_reload_reg_nxt = fast_capture_reload_reg_r;
      if (capreg_trig) begin
         fast_capture_reload_reg_nxt = tval[timer_pkg::FAST_AUX];
      end else if (wr_capreg) begin
         fast_capture_reload_reg_nxt = wmerge(fast_capture_reload_reg_r, wdata_r, wstrb_r);
      end
      core_otl_nxt = core_otl_r ^ wrap[timer_pkg::CORE];
      fast_otl_nxt = fast_otl_r ^ wrap[timer_pkg::FAST_CORE];
      core_out_nxt = core_otl_nxt & cfg_r[timer_pkg::CORE].out_en;
      fast_out_nxt = fast_otl_nxt & cfg_r[timer_pkg::FAST_CORE].out_en;
      cmp_clk_nxt = wrap[timer_pkg::FAST_CORE];
      // Sticky flags, set wins over clear
      flags_nxt = flags_r;
      if (wr_flags) begin
         flags_nxt = flags_r & ~wdata_r[timer_pkg::FLAGS_W-1:0];
      end
      flags_nxt[N-1:0] = flags_nxt[N-1:0] | wrap;
      flags_nxt[timer_pkg::FLG_CAP_LOW] = flags_nxt[timer_pkg::FLG_CAP_LOW] | cap_ev[timer_pkg::AUX_LOW];
      flags_nxt[timer_pkg::FLG_CAP_HIGH] = flags_nxt[timer_pkg::FLG_CAP_HIGH] | cap_ev[timer_pkg::AUX_HIGH];
      flags_nxt[timer_pkg::FLG_CAPREG] = flags_nxt[timer_pkg::FLG_CAPREG] | capreg_trig;
      flags_nxt[timer_pkg::FLG_INDEX] = flags_nxt[timer_pkg::FLG_INDEX] | (index_pulse_input & ~idx_r);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < N; i++) begin
            cfg_r[i] <= timer_pkg::cfg_t'(timer_pkg::CFG_RST);
         end
         fctl_r <= timer_pkg::fast_ctrl_t'(timer_pkg::FAST_CTRL_RST);
         fast_capture_reload_reg_r <= timer_pkg::VAL_RST;
         flags_r <= '0;
         pin_r <= '0;
         dpin_r <= '0;
         fpin_r <= '0;
         idx_r <= 1'b0;
         core_otl_r <= 1'b0;
         fast_otl_r <= 1'b0;
         core_out_r <= 1'b0;
         fast_out_r <= 1'b0;
         cmp_clk_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         fctl_r <= fctl_nxt;
         fast_capture_reload_reg_r <= fast_capture_reload_reg_nxt;
         flags_r <= flags_nxt;
         pin_r <= pin_nxt;
         dpin_r <= dpin_nxt;
         fpin_r <= fpin_nxt;
         idx_r <= idx_nxt;
         core_otl_r <= core_otl_nxt;
         fast_otl_r <= fast_otl_nxt;
         core_out_r <= core_out_nxt;
         fast_out_r <= fast_out_nxt;
         cmp_clk_r <= cmp_clk_nxt;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic [5:0] rd_idx;
   logic [31:0] rd_word;
   logic rd_hit;

   always_comb begin
      rd_idx = s_axi_req.araddr[7:2];
      rd_word = '0;
      rd_hit = 1'b1;
      if (rd_idx == timer_pkg::CAPREG_ADDR[7:2]) begin
         rd_word = {16'h0000, fast_capture_reload_reg_r};
      end else if (rd_idx == timer_pkg::FAST_CTRL_ADDR[7:2]) begin
         rd_word = {26'h0000000, fctl_r};
      end else if (rd_idx == timer_pkg::FLAGS_ADDR[7:2]) begin
         rd_word = {23'h000000, flags_r};
      end else begin
         rd_hit = 1'b0;
         for (int i = 0; i < N; i++) begin
            if (rd_idx == timer_pkg::CFG_ADDR[7:2] + 6'(i)) begin
               rd_word = {16'h0000, 16'(cfg_r[i])};
               rd_hit = 1'b1;
            end
            if (rd_idx == timer_pkg::VAL_ADDR[7:2] + 6'(i)) begin
               rd_word = {16'h0000, tval[i]};
               rd_hit = 1'b1;
            end
         end
      end
      awready_nxt = awready_r ? ~s_axi_req.awvalid : (bvalid_r & s_axi_req.bready);
      wready_nxt = wready_r ? ~s_axi_req.wvalid : (bvalid_r & s_axi_req.bready);
      awaddr_nxt = (awready_r & s_axi_req.awvalid) ? s_axi_req.awaddr : awaddr_r;
      wdata_nxt = (wready_r & s_axi_req.wvalid) ? s_axi_req.wdata : wdata_r;
      wstrb_nxt = (wready_r & s_axi_req.wvalid) ? s_axi_req.wstrb : wstrb_r;
      bvalid_nxt = wr_go | (bvalid_r & ~s_axi_req.bready);
      bresp_nxt = wr_go ? (wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR) : bresp_r;
      arready_nxt = arready_r ? ~s_axi_req.arvalid : (rvalid_r & s_axi_req.rready);
      rvalid_nxt = (arready_r & s_axi_req.arvalid) | (rvalid_r & ~s_axi_req.rready);
      rdata_nxt = (arready_r & s_axi_req.arvalid) ? rd_word : rdata_r;
      rresp_nxt = rresp_r;
      if (arready_r && s_axi_req.arvalid) begin
         rresp_nxt = rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= timer_pkg::RESP_OKAY;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= timer_pkg::RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
      end
   end

   assign s_axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r, bresp: bresp_r,
      arready: arready_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};
   assign core_toggle_out_pin = core_out_r;
   assign fast_toggle_out_pin = fast_out_r;
   assign compare_clock_out = cmp_clk_r;
endmodule

// File: timer_unit_props.sv
// Checker of the timer unit's bus answers and compare clock.
// Assumes it is bound to the top module; one clock domain.
module timer_unit_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire timer_pkg::axi_req_t s_axi_req,
   input wire timer_pkg::axi_rsp_t s_axi_rsp,
   input wire logic compare_clock_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr;
      s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready;
   endsequence
   sequence s_ar;
      s_axi_req.arvalid && s_axi_rsp.arready;
   endsequence
   chk_write_answer: assert property (s_wr |-> ##2 s_axi_rsp.bvalid) else $error("write answer late");
   chk_aw_blocked: assert property (s_wr |=> !s_axi_rsp.awready && !s_axi_rsp.wready) else $error("second write open");
   chk_read_answer: assert property (s_ar |=> s_axi_rsp.rvalid) else $error("read answer late");
   chk_b_single: assert property (s_axi_rsp.bvalid && s_axi_req.bready |=> !s_axi_rsp.bvalid) else $error("b repeated");
   chk_upper_zero: assert property (s_axi_rsp.rvalid |-> s_axi_rsp.rdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   chk_bad_read: assert property (s_ar ##0 s_axi_req.araddr[7:2] > timer_pkg::FLAGS_ADDR[7:2]
      |=> s_axi_rsp.rresp == timer_pkg::RESP_SLVERR && s_axi_rsp.rdata == 32'h0) else $error("unmapped read ok");
   chk_cmp_pulse: assert property (compare_clock_out |=> !compare_clock_out) else $error("clock pulse long");
   chk_reset_idle: assert property ($rose(aresetn) |-> s_axi_rsp.awready && s_axi_rsp.arready
      && !s_axi_rsp.bvalid && !compare_clock_out) else $error("not idle after reset");
endmodule
bind dual_module_timer_unit timer_unit_props u_props (.aclk, .aresetn, .s_axi_req, .s_axi_rsp, .compare_clock_out);

// File: pins_model.sv
// Pin model: quadrature sensor on the core timer and a capture pin.
// Assumes the bench calls its tasks right after a rising edge.
module pins_model (
   input wire logic aclk,
   output logic [4:0] tin,
   output logic [4:0] tdir,
   output logic cap
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {tin, tdir, cap} = 11'h000;
   task automatic quad(input logic fwd, input int n);
      repeat (n) begin
         @(posedge aclk);
         if ((tin[1] == tdir[1]) == fwd) tin[1] <= ~tin[1];
         else tdir[1] <= ~tdir[1];
         repeat (8) @(posedge aclk);
      end
   endtask
   task automatic pulse();
      @(posedge aclk);
      cap <= 1'b1;
      repeat (8) @(posedge aclk);
      cap <= 1'b0;
   endtask
endmodule

// File: tb.sv
// Bench of the five-timer unit: register master, pin model, checks.
// Assumes the checker is bound to the unit by its own file.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] C1 = 8'h04, C4 = 8'h10, V1 = 8'h24, V3 = 8'h2C, V4 = 8'h30;
   logic aclk;
   logic aresetn;
   timer_pkg::axi_req_t rq;
   timer_pkg::axi_rsp_t rs;
   logic [4:0] tin;
   logic [4:0] tdir;
   logic cap;
   logic c_out;
   logic f_out;
   logic cmp_o;
   int n_errors = 0;
   int compares = 0;
   int n_cmp = 0;
   logic [31:0] d;
   logic [31:0] v;
   logic [1:0] e;
   dual_module_timer_unit u_dut (.aclk, .aresetn, .s_axi_req(rq), .s_axi_rsp(rs), .timer_input_pin(tin),
      .direction_input_pin(tdir), .capture_input_pin(cap), .index_pulse_input(cap),
      .core_toggle_out_pin(c_out), .fast_toggle_out_pin(f_out), .compare_clock_out(cmp_o));
   pins_model u_pins (.aclk, .tin, .tdir, .cap);
   // Count exported wrap clock pulses
   always @(posedge aclk) begin
      if (cmp_o) n_cmp++;
   end
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] w);
      @(posedge aclk);
      rq <= '{1'b1, a, 1'b1, {16'h0000, w}, 4'hF, 1'b1, 1'b0, 8'h00, 1'b0};
      do begin
         @(posedge aclk);
         if (rs.awready) rq.awvalid <= 1'b0;
         if (rs.wready) rq.wvalid <= 1'b0;
      end while (!rs.bvalid);
      e = rs.bresp;
      rq.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      rq <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
      do begin
         @(posedge aclk);
         if (rs.arready) rq.arvalid <= 1'b0;
      end while (!rs.rvalid);
      d = rs.rdata;
      e = rs.rresp;
      rq.rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      rd(a);
      chk(d & m, x);
   endtask
   task automatic t_regs();
      rc(C1, 32'hFFFFFFFF, 32'h0);
      wr(C1, 16'h476B);
      rc(C1, 32'hFFFFFFFF, 32'h476B);
      wr(8'h4C, 16'h0001);
      chk({30'h0, e}, 32'h2);
      rd(8'h4C);
      chk(d, 32'h0);
      chk({30'h0, e}, 32'h2);
      wr(C1, 16'h0000);
   endtask
   task automatic t_rate();
      wr(V1, 16'h0000);
      wr(C1, 16'h000C);
      rd(V1);
      v = d;
      repeat (37) @(posedge aclk);
      rd(V1);
      chk(d - v, 32'h5);
      wr(C1, 16'h0000);
   endtask
   task automatic t_wrap();
      wr(V1, 16'hFFFE);
      wr(V4, 16'hFFFF);
      wr(C4, 16'h4004);
      wr(C1, 16'h4004);
      repeat (12) @(posedge aclk);
      chk({30'h0, c_out, f_out}, 32'h3);
      chk(n_cmp, 32'h1);
      rc(8'h48, 32'h12, 32'h12);
      wr(8'h48, 16'h0012);
      rc(8'h48, 32'h12, 32'h0);
      wr(C4, 16'h0000);
   endtask
   task automatic t_quad();
      wr(8'h44, 16'h000C);
      wr(V3, 16'h0055);
      wr(C1, 16'h0007);
      wr(V1, 16'h0000);
      u_pins.quad(1'b1, 4);
      rd(V1);
      chk(d, 32'h4);
      u_pins.quad(1'b0, 4);
      rc(V1, 32'hFFFFFFFF, 32'h0);
      rc(8'h40, 32'hFFFFFFFF, 32'h55);
   endtask
   task automatic t_cap();
      wr(C1, 16'h0000);
      wr(8'h44, 16'h0021);
      wr(8'h48, 16'h01FF);
      wr(V3, 16'h1234);
      u_pins.pulse();
      rc(8'h40, 32'hFFFFFFFF, 32'h1234);
      rc(V3, 32'hFFFFFFFF, 32'h0);
      rc(8'h48, 32'h180, 32'h180);
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      rq = '0;
      aresetn = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_rate();
      t_wrap();
      t_quad();
      t_cap();
      give_verdict();
   end
   initial begin
      #2000000;
      n_errors++;
      give_verdict();
   end
endmodule
